// ==== verilog/dmaisl_pkg.sv ====
package dmaisl_pkg;

    localparam int NUM_CH = 2;
    localparam int NUM_TYPES = 5;

    // Event type index, also the register slot within each group
    localparam logic [2:0] EV_TFR = 3'h0;
    localparam logic [2:0] EV_BLOCK = 3'h1;
    localparam logic [2:0] EV_SRC_TXN = 3'h2;
    localparam logic [2:0] EV_DST_TXN = 3'h3;
    localparam logic [2:0] EV_ERR = 3'h4;

    // Register groups: slot n sits at base + n * step
    localparam logic [31:0] REG_STEP = 32'h0000_0008;
    localparam logic [31:0] RAW_BASE = 32'hb070_02c0;
    localparam logic [31:0] STATUS_BASE = 32'hb070_02e8;
    localparam logic [31:0] MASK_BASE = 32'hb070_0310;
    localparam logic [31:0] CLEAR_BASE = 32'hb070_0338;

    localparam logic [31:0] DEST_TXN_DONE_RAW_ADDR = 32'hb070_02d8;
    localparam logic [31:0] BUS_ERROR_RAW_ADDR = 32'hb070_02e0;
    localparam logic [31:0] TRANSFER_DONE_MASKED_ADDR = 32'hb070_02e8;
    localparam logic [31:0] BLOCK_DONE_MASKED_ADDR = 32'hb070_02f0;
    localparam logic [31:0] SOURCE_TXN_DONE_MASKED_ADDR = 32'hb070_02f8;

    // Field layout
    localparam int CH_LSB = 0;
    localparam int MASK_WE_LSB = 8;
    localparam logic [1:0] RAW_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [1:0] ABORT_RST = 2'h0;
    localparam logic [4:0] IRQ_RST = 5'h00;

    // Sides on which bus error detection exists, one bit per channel
    localparam logic [1:0] SRC_ERR_EN = 2'h2;
    localparam logic [1:0] DST_ERR_EN = 2'h1;

    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic HRESP_ERROR = 1'b1;

    typedef enum logic [4:0] {
        RK_NONE = 5'h01,
        RK_RAW = 5'h02,
        RK_STATUS = 5'h04,
        RK_MASK = 5'h08,
        RK_CLEAR = 5'h10
    } dmaisl_kind_t;

    typedef struct packed {
        dmaisl_kind_t kind;
        logic [2:0] idx;
    } dmaisl_dec_t;

    typedef struct packed {
        logic wr;
        dmaisl_dec_t dec;
    } dmaisl_dph_t;

endpackage : dmaisl_pkg

// ==== verilog/dmaisl_evt_unit.sv ====
`timescale 1ns/1ps
module dmaisl_evt_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] evt_i,
    input wire logic raw_we_i,
    input wire logic clr_we_i,
    input wire logic mask_we_i,
    input wire logic [31:0] wdata_i,
    output logic [1:0] raw_o,
    output logic [1:0] mask_o,
    output logic [1:0] status_o
);
    logic [1:0] raw_q;
    logic [1:0] raw_d;
    logic [1:0] mask_q;
    logic [1:0] mask_d;

    always_comb begin
        raw_d = raw_q;
        if (raw_we_i) begin
            raw_d = wdata_i[1:0];
        end
        if (clr_we_i) begin
            raw_d = raw_d & ~wdata_i[1:0];
        end
        // Event after clear so a same-cycle event survives
        raw_d = raw_d | evt_i;
        mask_d = mask_q;
        for (int c = 0; c < dmaisl_pkg::NUM_CH; c++) begin
            if (mask_we_i && wdata_i[dmaisl_pkg::MASK_WE_LSB + c]) begin
                mask_d[c] = wdata_i[dmaisl_pkg::CH_LSB + c];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            raw_q <= dmaisl_pkg::RAW_RST;
            mask_q <= dmaisl_pkg::MASK_RST;
        end else begin
            raw_q <= raw_d;
            mask_q <= mask_d;
        end
    end

    assign raw_o = raw_q;
    assign mask_o = mask_q;
    assign status_o = raw_q & mask_q;
endmodule : dmaisl_evt_unit

// ==== verilog/dmaisl_top.sv ====
`timescale 1ns/1ps
module dmaisl_top (
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic HWRITE_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic [1:0] TRANSFER_DONE_EVENT_I,
    input wire logic [1:0] BLOCK_DONE_EVENT_I,
    input wire logic [1:0] SOURCE_TXN_DONE_EVENT_I,
    input wire logic [1:0] DEST_TXN_DONE_EVENT_I,
    input wire logic [1:0] DEST_IS_MEM_I,
    input wire logic MST_HRESP_I,
    input wire logic MST_HREADY_I,
    input wire logic [1:0] SRC_DPHASE_I,
    input wire logic [1:0] DST_DPHASE_I,
    output logic [1:0] CH_ABORT_O,
    output logic INT_TFR_O,
    output logic INT_BLOCK_O,
    output logic INT_SRC_TXN_O,
    output logic INT_DST_TXN_O,
    output logic INT_ERR_O
);
    localparam int NT = dmaisl_pkg::NUM_TYPES;

    // Full 32-bit compare; any other address is a hole reading zero
    function automatic dmaisl_pkg::dmaisl_dec_t decode(
        input logic [31:0] a
    );
        dmaisl_pkg::dmaisl_dec_t r;
        logic [31:0] off;
        r.kind = dmaisl_pkg::RK_NONE;
        r.idx = 3'h0;
        for (int t = 0; t < NT; t++) begin
            off = 32'(dmaisl_pkg::REG_STEP * 32'(t));
            if (a == dmaisl_pkg::RAW_BASE + off) begin
                r.kind = dmaisl_pkg::RK_RAW;
                r.idx = 3'(t);
            end
            if (a == dmaisl_pkg::STATUS_BASE + off) begin
                r.kind = dmaisl_pkg::RK_STATUS;
                r.idx = 3'(t);
            end
            if (a == dmaisl_pkg::MASK_BASE + off) begin
                r.kind = dmaisl_pkg::RK_MASK;
                r.idx = 3'(t);
            end
            if (a == dmaisl_pkg::CLEAR_BASE + off) begin
                r.kind = dmaisl_pkg::RK_CLEAR;
                r.idx = 3'(t);
            end
        end
        return r;
    endfunction : decode

    logic [NT-1:0][1:0] evt;
    logic [NT-1:0][1:0] raw;
    logic [NT-1:0][1:0] mask;
    logic [NT-1:0][1:0] status;
    logic [NT-1:0] raw_we;
    logic [NT-1:0] clr_we;
    logic [NT-1:0] mask_we;
    logic [1:0] err_hit;

    dmaisl_pkg::dmaisl_dph_t dph_q;
    dmaisl_pkg::dmaisl_dph_t dph_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] abort_q;
    logic [1:0] abort_d;
    logic [NT-1:0] irq_q;
    logic [NT-1:0] irq_d;

    // Only the first cycle of the two-cycle error answer is taken,
    // so each error gives one event.
    always_comb begin
        err_hit = 2'h0;
        if (MST_HRESP_I == dmaisl_pkg::HRESP_ERROR && !MST_HREADY_I) begin
            err_hit = (SRC_DPHASE_I & dmaisl_pkg::SRC_ERR_EN)
                    | (DST_DPHASE_I & dmaisl_pkg::DST_ERR_EN);
        end
        evt[dmaisl_pkg::EV_TFR] = TRANSFER_DONE_EVENT_I;
        evt[dmaisl_pkg::EV_BLOCK] = BLOCK_DONE_EVENT_I;
        evt[dmaisl_pkg::EV_SRC_TXN] = SOURCE_TXN_DONE_EVENT_I;
        // Memory destination has no transaction level
        evt[dmaisl_pkg::EV_DST_TXN] =
            DEST_TXN_DONE_EVENT_I & ~DEST_IS_MEM_I;
        evt[dmaisl_pkg::EV_ERR] = err_hit;
    end

    // One unit per event type, all written through the same data phase
    for (genvar t = 0; t < NT; t++) begin : g_unit
        dmaisl_evt_unit u_unit (
            .clk_i(REF_CLK_I),
            .rst_i(SYS_RST_I),
            .evt_i(evt[t]),
            .raw_we_i(raw_we[t]),
            .clr_we_i(clr_we[t]),
            .mask_we_i(mask_we[t]),
            .wdata_i(HWDATA_I),
            .raw_o(raw[t]),
            .mask_o(mask[t]),
            .status_o(status[t])
        );
    end

    // Data phase write strobes
    always_comb begin
        raw_we = '0;
        clr_we = '0;
        mask_we = '0;
        if (dph_q.wr) begin
            unique case (dph_q.dec.kind)
                dmaisl_pkg::RK_RAW: raw_we[dph_q.dec.idx] = 1'b1;
                dmaisl_pkg::RK_CLEAR: clr_we[dph_q.dec.idx] = 1'b1;
                dmaisl_pkg::RK_MASK: mask_we[dph_q.dec.idx] = 1'b1;
                dmaisl_pkg::RK_STATUS: ; // Read-only, write dropped
                dmaisl_pkg::RK_NONE: ;
            endcase
        end
    end

    // Address phase: latch decode, prepare read data
    always_comb begin
        dmaisl_pkg::dmaisl_dec_t dec;
        dec = decode(HADDR_I);
        dph_d = '0;
        dph_d.dec.kind = dmaisl_pkg::RK_NONE;
        rdata_d = rdata_q;
        if (HSEL_I && HREADY_I && (HTRANS_I & dmaisl_pkg::HTRANS_NONSEQ_BIT)
                != 2'h0) begin
            dph_d.wr = HWRITE_I;
            dph_d.dec = dec;
            rdata_d = dmaisl_pkg::RDATA_RST;
            if (!HWRITE_I) begin
                unique case (dec.kind)
                    dmaisl_pkg::RK_RAW: rdata_d[1:0] = raw[dec.idx];
                    dmaisl_pkg::RK_STATUS:
                        rdata_d[1:0] = status[dec.idx];
                    dmaisl_pkg::RK_MASK: begin
                        rdata_d[1:0] = mask[dec.idx];
                    end
                    dmaisl_pkg::RK_CLEAR: ;
                    dmaisl_pkg::RK_NONE: ;
                endcase
            end
        end
    end

    // Bus state: data phase decode and read data
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            dph_q <= '{wr: 1'b0, dec: '{kind: dmaisl_pkg::RK_NONE,
                                        idx: 3'h0}};
            rdata_q <= dmaisl_pkg::RDATA_RST;
        end else begin
            dph_q <= dph_d;
            rdata_q <= rdata_d;
        end
    end

    // One-cycle pulse; the engine drops the channel on it.
    // Registered so a glitch on the master bus cannot cancel.
    always_comb begin
        abort_d = err_hit;
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            abort_q <= dmaisl_pkg::ABORT_RST;
        end else begin
            abort_q <= abort_d;
        end
    end

    // Levels are one cycle late, but no decode glitch
    // ever reaches an interrupt pin.
    always_comb begin
        for (int t = 0; t < NT; t++) begin
            irq_d[t] = |status[t];
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            irq_q <= dmaisl_pkg::IRQ_RST;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Zero-wait slave; every access answers OKAY
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = dmaisl_pkg::HRESP_OKAY;
    assign HRDATA_O = rdata_q;
    assign CH_ABORT_O = abort_q;
    assign INT_TFR_O = irq_q[dmaisl_pkg::EV_TFR];
    assign INT_BLOCK_O = irq_q[dmaisl_pkg::EV_BLOCK];
    assign INT_SRC_TXN_O = irq_q[dmaisl_pkg::EV_SRC_TXN];
    assign INT_DST_TXN_O = irq_q[dmaisl_pkg::EV_DST_TXN];
    assign INT_ERR_O = irq_q[dmaisl_pkg::EV_ERR];
endmodule : dmaisl_top

// ==== tb/dmaisl_sva.sv ====
`timescale 1ns/1ps
module dmaisl_sva (
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic HWRITE_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic [1:0] DEST_TXN_DONE_EVENT_I,
    input wire logic [1:0] DEST_IS_MEM_I,
    input wire logic MST_HRESP_I,
    input wire logic MST_HREADY_I,
    input wire logic [1:0] SRC_DPHASE_I,
    input wire logic [1:0] DST_DPHASE_I,
    input wire logic [1:0] CH_ABORT_O,
    input wire logic INT_TFR_O,
    input wire logic INT_DST_TXN_O,
    input wire logic INT_ERR_O
);
    logic acc;
    logic wr;
    logic eh;
    logic e0;
    logic e1;
    logic [1:0] dst_ev;
    assign acc = HSEL_I && HREADY_I && HTRANS_I[1];
    assign wr = acc && HWRITE_I;
    assign eh = MST_HRESP_I && !MST_HREADY_I;
    // Only ch0 destination and ch1 source can see an error
    assign e0 = eh && DST_DPHASE_I[0];
    assign e1 = eh && SRC_DPHASE_I[1];
    assign dst_ev = DEST_TXN_DONE_EVENT_I & ~DEST_IS_MEM_I;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    // Clear registers and everything above them read back zero
    sequence s_rd_hole;
        acc && !HWRITE_I && HADDR_I >= 32'hb070_0338;
    endsequence
    sequence s_err_c0;
        eh && DST_DPHASE_I[0];
    endsequence
    a_rsv_zero: assert property (HRDATA_O[31:2] == 30'h0)
        else $error("reserved read bits set");
    a_hole_zero: assert property (s_rd_hole |=> HRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_abort_c0: assert property (s_err_c0 |=> CH_ABORT_O[0])
        else $error("ch0 abort missing");
    a_abort_why0: assert property (CH_ABORT_O[0] |-> $past(e0))
        else $error("ch0 abort without cause");
    a_abort_why1: assert property
        (CH_ABORT_O[1] |-> $past(e1))
        else $error("ch1 abort without cause");
    // Event at edge N shows on a pin sampled high at N+2; a write
    // lands one edge after its address, so its pin follows at +3
    a_dst_int_cause: assert property ($rose(INT_DST_TXN_O) |->
        $past(dst_ev, 2) != 2'h0 || $past(wr, 3))
        else $error("dst interrupt without cause");
    a_err_int_cause: assert property ($rose(INT_ERR_O) |->
        $past(e0, 2) || $past(e1, 2) || $past(wr, 3))
        else $error("error interrupt without cause");
    a_tfr_int_drop: assert property ($fell(INT_TFR_O) |-> $past(wr, 3))
        else $error("transfer interrupt fell alone");
    a_zero_wait: assert property (HREADYOUT_O && !HRESP_O)
        else $error("register access stalled or errored");
endmodule : dmaisl_sva
bind dmaisl_top dmaisl_sva u_sva (.*);

// ==== tb/dmaisl_fab.sv ====
`timescale 1ns/1ps
module dmaisl_fab (
    input wire logic clk_i,
    output logic hresp_o,
    output logic hready_o
);
    initial begin
        hresp_o = 1'b0;
        hready_o = 1'b1;
    end
    // Two-cycle error reply, ready low first; call just after a fall
    task automatic error_reply;
        hresp_o = 1'b1;
        hready_o = 1'b0;
        @(negedge clk_i);
        hready_o = 1'b1;
        @(negedge clk_i);
        hresp_o = 1'b0;
    endtask : error_reply
endmodule : dmaisl_fab

// ==== tb/tb_dma_interrupt_status_logic.sv ====
`timescale 1ns/1ps
module tb_dma_interrupt_status_logic;
    localparam logic [31:0] RB = dmaisl_pkg::RAW_BASE;
    localparam logic [31:0] SB = dmaisl_pkg::STATUS_BASE;
    localparam logic [31:0] MB = dmaisl_pkg::MASK_BASE;
    localparam logic [31:0] CB = dmaisl_pkg::CLEAR_BASE;
    localparam logic [1:0] ERRX [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0;
    logic wrt = 1'b0;
    logic [1:0] trn = 2'h0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wd = 32'h0;
    logic [1:0] ev [4] = '{default: 2'h0};
    logic [1:0] mem = 2'h0;
    logic [1:0] sph = 2'h0;
    logic [1:0] dph = 2'h0;
    logic [31:0] rdat;
    logic hresp;
    logic hrdy;
    logic [1:0] abrt;
    logic [1:0] ab_seen = 2'h0;
    logic [4:0] ints;
    int n_fail = 0;
    int checked = 0;
    dmaisl_fab fab (.clk_i(clk), .hresp_o(hresp), .hready_o(hrdy));
    dmaisl_top dut (
        .REF_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(sel), .HADDR_I(adr),
        .HWRITE_I(wrt), .HTRANS_I(trn), .HWDATA_I(wd), .HREADY_I(1'b1),
        .HRDATA_O(rdat), .HREADYOUT_O(), .HRESP_O(),
        .TRANSFER_DONE_EVENT_I(ev[0]), .BLOCK_DONE_EVENT_I(ev[1]),
        .SOURCE_TXN_DONE_EVENT_I(ev[2]), .DEST_TXN_DONE_EVENT_I(ev[3]),
        .DEST_IS_MEM_I(mem), .MST_HRESP_I(hresp), .MST_HREADY_I(hrdy),
        .SRC_DPHASE_I(sph), .DST_DPHASE_I(dph), .CH_ABORT_O(abrt),
        .INT_TFR_O(ints[0]), .INT_BLOCK_O(ints[1]), .INT_SRC_TXN_O(ints[2]),
        .INT_DST_TXN_O(ints[3]), .INT_ERR_O(ints[4]));
    initial begin
        forever #4 clk = ~clk;
    end
    // Aborts gather between bus accesses; each access starts afresh
    always @(posedge clk) ab_seen <= sel ? 2'h0 : ab_seen | abrt;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // Read data is compared in its data phase, write data sent there
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, input logic [31:0] e);
        @(negedge clk);
        {sel, wrt, trn, adr} = {1'b1, w, 2'h2, a};
        @(negedge clk);
        {sel, trn, wd} = {1'b0, 2'h0, d};
        if (!w) chk(rdat, e);
    endtask : bus
    task automatic pulse(input int t, input logic [1:0] v);
        @(negedge clk);
        ev[t] = v;
        @(negedge clk);
        ev[t] = 2'h0;
    endtask : pulse
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 20; i++) begin
            bus(1'b0, RB + 32'(i * 8), 32'h0, 32'h0);
        end
        bus(1'b0, 32'hb070_0400, 32'h0, 32'h0);
        $display("reset values test done");
        for (int t = 0; t < 4; t++) begin
            bus(1'b1, MB + 32'(t * 8), 32'h0000_0303, 32'h0);
            pulse(t, 2'h1);
            bus(1'b0, RB + 32'(t * 8), 32'h0, 32'h1);
            bus(1'b0, SB + 32'(t * 8), 32'h0, 32'h1);
            chk({27'h0, ints}, 32'h1 << t);
            bus(1'b1, CB + 32'(t * 8), 32'h1, 32'h0);
            bus(1'b0, RB + 32'(t * 8), 32'h0, 32'h0);
            chk({27'h0, ints}, 32'h0);
        end
        $display("event types test done");
        bus(1'b1, MB, 32'h0000_0002, 32'h0);
        bus(1'b0, MB, 32'h0, 32'h3);
        bus(1'b1, MB, 32'h0000_0100, 32'h0);
        bus(1'b0, MB, 32'h0, 32'h2);
        pulse(0, 2'h3);
        bus(1'b0, SB, 32'h0, 32'h2);
        bus(1'b1, SB, 32'h3, 32'h0);
        bus(1'b0, SB, 32'h0, 32'h2);
        bus(1'b1, CB, 32'h3, 32'h0);
        $display("mask enable test done");
        bus(1'b1, RB, 32'hffff_ffff, 32'h0);
        bus(1'b0, RB, 32'h0, 32'h3);
        chk({27'h0, ints}, 32'h1);
        bus(1'b1, CB, 32'h3, 32'h0);
        bus(1'b0, RB, 32'h0, 32'h0);
        chk({27'h0, ints}, 32'h0);
        $display("raw write test done");
        mem = 2'h2;
        pulse(3, 2'h3);
        bus(1'b0, RB + 32'h18, 32'h0, 32'h1);
        bus(1'b1, CB + 32'h18, 32'h3, 32'h0);
        $display("memory destination test done");
        bus(1'b1, MB + 32'h20, 32'h0000_0303, 32'h0);
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            {dph, sph} = 4'h1 << k;
            fab.error_reply();
            {dph, sph} = 4'h0;
            chk({30'h0, ab_seen}, {30'h0, ERRX[k]});
            bus(1'b0, RB + 32'h20, 32'h0, {30'h0, ERRX[k]});
            bus(1'b1, CB + 32'h20, 32'h3, 32'h0);
        end
        $display("bus error test done");
        tally_and_finish();
    end
endmodule : tb_dma_interrupt_status_logic
